//--- test/scsmd_properties.sv
`timescale 1ns/1ps
module scsmd_properties
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic backup_por,
  input wire logic rc_osc_tick,
  input wire logic xtal_osc_tick,
  input wire logic slow_clk_in,
  input wire logic main_pll_tick,
  input wire logic usb_pll_tick,
  input wire logic slow_clk_tick,
  input wire logic cpu_clk_tick,
  input wire logic master_clk_tick,
  input wire logic ddr_clk_tick,
  input wire logic ddr_clk_avail,
  input wire logic fs_usb_tick,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  // both resets mute the checks; slow state is only defined after backup reset
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (sys_rst || backup_por);
  // ddr tick is registered, so it follows the ratio of the cycle before
  chk_no_ddr_div1: assert property (!$past(ddr_clk_avail) |-> !ddr_clk_tick)
    else $error("ddr tick while divider is one");
  chk_master_cause: assert property (master_clk_tick |-> cpu_clk_tick)
    else $error("master tick without cpu tick");
  chk_ddr_pair: assert property (master_clk_tick && $past(ddr_clk_avail) |-> ddr_clk_tick)
    else $error("master edge without ddr edge");
  chk_cpu_cause: assert property (cpu_clk_tick |-> $past(main_pll_tick || usb_pll_tick))
    else $error("cpu tick without pll tick");
  chk_fs_cause: assert property (fs_usb_tick |-> $past(main_pll_tick || usb_pll_tick))
    else $error("fs tick without input tick");
  // bypass edge may take one extra cycle to detect, the input stays high 3 cycles
  chk_slow_cause: assert property (slow_clk_tick |-> $past(rc_osc_tick || xtal_osc_tick || slow_clk_in))
    else $error("slow tick without source tick");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  cov_master: cover property (master_clk_tick && ddr_clk_tick);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cov_bypass: cover property (slow_clk_tick && slow_clk_in);
endmodule
bind scsmd_top scsmd_properties chk (.*);

//--- test/scsmd_test.sv
`timescale 1ns/1ps
module scsmd_test;
  import scsmd_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  logic backup_por = 1;
  logic rc_osc_tick = 0, xtal_osc_tick = 0, slow_clk_in = 0, main_pll_tick = 0, usb_pll_tick = 0;
  logic ext_on = 0;
  logic rc_osc_run, xtal_osc_run, slow_clk_tick, cpu_clk_tick, master_clk_tick;
  logic ddr_clk_tick, ddr_clk_avail, fs_usb_tick;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rdv;
  int mismatches = 0, num_checks = 0, cyc = 0;
  int cnt [7];
  scsmd_top uut (.*);
  always #2 clock = ~clock;
  // oscillator models run only while the block enables them; also the hang limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    main_pll_tick <= ~main_pll_tick;
    // usb pll slower than main pll so the two sources can be told apart
    usb_pll_tick <= (cyc % 3 == 0);
    rc_osc_tick <= (rc_osc_run === 1'b1) && (cyc % 8 == 0);
    xtal_osc_tick <= (xtal_osc_run === 1'b1) && (cyc % 5 == 0);
    slow_clk_in <= ext_on && (cyc % 6 < 3);
    if (cyc == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  // handshakes are judged mid-cycle so the sample never races the edge
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    tb = 0;
    while (!tb)
    begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    // let an edge pass so the next call never reassigns bready in this step
    @(posedge clock);
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    tr = 0;
    while (!tr)
    begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    @(posedge clock);
  endtask
  // counts ticks of each derived clock and the usb pll between n ticks of source r; slot 6 counts cycles
  task span(input int r, input int n);
    logic [6:0] tk;
    int k;
    cnt = '{default: 0};
    k = -1;
    while (k < n)
    begin
      @(negedge clock);
      tk = {1'b1, slow_clk_tick, fs_usb_tick, usb_pll_tick, ddr_clk_tick, cpu_clk_tick, master_clk_tick};
      if (k >= 0) for (int i = 0; i < 7; i++) cnt[i] += tk[i];
      if (tk[r]) k++;
    end
    @(posedge clock);
  endtask
  task t_reset();
    rd(SLOW_CTL_OFFSET);
    chk("slow ctl", 32'h0000_0001, rdv);
    rd(DIV_CTL_OFFSET);
    chk("div ctl", 32'h0000_0093, rdv);
    chk("xtal off", 0, xtal_osc_run);
  endtask
  // the first span lets a changed ratio settle before measuring
  task t_div();
    int r;
    for (int c = 0; c < 4; c++)
    begin
      // code 10 divides by four, code 11 by three
      r = (c == 2) ? 4 : (c == 3) ? 3 : c + 1;
      wr(DIV_CTL_OFFSET, 32'h0000_0090 | c);
      span(0, 2);
      span(0, 12);
      chk("cpu per master", 12 * r, cnt[1]);
      chk("ddr per master", c == 0 ? 0 : 24, cnt[2]);
      chk("ddr avail", c != 0, ddr_clk_avail);
    end
  endtask
  task t_fs();
    int dv;
    for (int j = 0; j < 2; j++)
    begin
      dv = (j == 0) ? 7 : 9;
      wr(DIV_CTL_OFFSET, (dv << 4) | 3);
      span(4, 1);
      span(4, 4);
      chk("usb per fs", 4 * (dv + 1), cnt[3]);
    end
    // fs divider fed from the main pll, one tick every second cycle
    wr(DIV_CTL_OFFSET, 32'h0000_0273);
    span(4, 1);
    span(4, 4);
    chk("cycles per fs main", 64, cnt[6]);
  endtask
  task t_usb();
    wr(DIV_CTL_OFFSET, 32'h0000_0190);
    span(0, 2);
    span(0, 12);
    chk("usb per cpu", 24, cnt[3]);
  endtask
  task t_slow();
    wr(SLOW_CTL_OFFSET, 32'h0000_0003);
    chk("xtal run", 1, xtal_osc_run);
    span(5, 2);
    chk("rc period", 16, cnt[6]);
    wr(SLOW_CTL_OFFSET, 32'h0000_000b);
    rd(STATUS_OFFSET);
    chk("busy", 2'b10, rdv[1:0]);
    repeat (40) @(posedge clock);
    rd(STATUS_OFFSET);
    chk("switched", 2'b01, rdv[1:0]);
    span(5, 2);
    chk("xtal period", 10, cnt[6]);
    wr(SLOW_CTL_OFFSET, 32'h0000_000a);
    chk("rc run", 0, rc_osc_run);
    ext_on <= 1;
    wr(SLOW_CTL_OFFSET, 32'h0000_000e);
    wr(SLOW_CTL_OFFSET, 32'h0000_000c);
    span(5, 2);
    chk("bypass period", 12, cnt[6]);
    wr(SLOW_CTL_OFFSET, 32'h0000_000d);
    wr(SLOW_CTL_OFFSET, 32'h0000_0005);
    repeat (60) @(posedge clock);
    span(5, 2);
    chk("back to rc", 16, cnt[6]);
  endtask
  task t_bus();
    wr(28'hfff_fd5c, 32'h0000_00ff);
    chk("unmapped wr", RESP_SLVERR, resp);
    wr(STATUS_OFFSET, 32'h0000_0000);
    chk("status wr", RESP_SLVERR, resp);
    rd(28'hfff_fd5c);
    chk("unmapped rd", RESP_SLVERR, resp);
    chk("unmapped data", 0, rdv);
  endtask
  // core reset must leave the backup bits alone, backup reset restores them
  task t_keep();
    sys_rst <= 1;
    repeat (3) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    rd(SLOW_CTL_OFFSET);
    chk("retained", 32'h0000_0005, rdv);
    rd(DIV_CTL_OFFSET);
    chk("div after reset", DIV_CTL_RST, rdv);
    backup_por <= 1;
    repeat (3) @(posedge clock);
    backup_por <= 0;
    @(posedge clock);
    rd(SLOW_CTL_OFFSET);
    chk("backup reset", SLOW_CTL_RST, rdv);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    backup_por <= 0;
    @(posedge clock);
    t_reset();
    t_div();
    t_fs();
    t_usb();
    t_slow();
    t_bus();
    t_keep();
    print_verdict();
  end
endmodule

//--- verilog/scsmd_pkg.sv
package scsmd_pkg;
  // register bus geometry
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] SLOW_CTL_OFFSET = 28'hfff_fd50;
  localparam logic [ADDR_W-1:0] DIV_CTL_OFFSET = 28'hfff_fd54;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 28'hfff_fd58;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // slow clock control field positions (low byte)
  localparam int RC_OSC_ON_BIT = 0;
  localparam int XTAL_OSC_ON_BIT = 1;
  localparam int XTAL_BYPASS_BIT = 2;
  localparam int SLOW_SRC_SEL_BIT = 3;
  localparam int SLOW_CTL_W = 4;
  // divider control field positions
  localparam int MASTER_DIV_CODE_LSB = 0;
  localparam int FS_DIV_LSB = 4;
  localparam int USB_SYS_MODE_BIT = 8;
  localparam int FS_SRC_MAIN_BIT = 9;
  localparam int DIV_CTL_W = 10;
  // status field positions
  localparam int STS_ACTIVE_SEL_BIT = 0;
  localparam int STS_SWITCH_BUSY_BIT = 1;
  localparam int STS_DDR_AVAIL_BIT = 2;
  // slow control word, low bit first: rc on, xtal on, bypass, select
  typedef struct packed {
    logic slow_src_sel;
    logic xtal_bypass;
    logic xtal_osc_on;
    logic rc_osc_on;
  } scsmd_slow_ctl_t;
  typedef struct packed {
    logic fs_src_main;
    logic usb_sys_mode;
    logic [3:0] fs_usb_div;
    logic [1:0] rsvd;
    logic [1:0] master_div_code;
  } scsmd_div_ctl_t;
  // reset values: start on rc, divider /3, fs divider 9
  localparam logic [SLOW_CTL_W-1:0] SLOW_CTL_RST = 4'h1;
  localparam logic [DIV_CTL_W-1:0] DIV_CTL_RST = 10'h093;
  // master divider codes
  localparam logic [1:0] MASTER_DIV_CODE_DIV1 = 2'b00;
  localparam logic [1:0] MASTER_DIV_CODE_DIV2 = 2'b01;
  localparam logic [1:0] MASTER_DIV_CODE_DIV4 = 2'b10;
  localparam logic [1:0] MASTER_DIV_CODE_DIV3 = 2'b11;
  // select resynchronisation length in slow clock cycles
  localparam logic [2:0] SLOW_RESYNC_CYCLES = 3'h5;
  // switch state machine
  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_RESYNC = 2'b10
  } scsmd_sw_state_t;
endpackage

//--- verilog/scsmd_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module scsmd_top
  import scsmd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic backup_por,
  // oscillator and pll ticks, one cycle each; slow_clk_in is a level whose rising edges are detected
  input wire logic rc_osc_tick,
  input wire logic xtal_osc_tick,
  input wire logic slow_clk_in,
  input wire logic main_pll_tick,
  input wire logic usb_pll_tick,
  output logic rc_osc_run,
  output logic xtal_osc_run,
  output logic slow_clk_tick,
  output logic cpu_clk_tick,
  output logic master_clk_tick,
  output logic ddr_clk_tick,
  output logic ddr_clk_avail,
  output logic fs_usb_tick,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // address decode shared by read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == SLOW_CTL_OFFSET) || (a == DIV_CTL_OFFSET) || (a == STATUS_OFFSET);
  endfunction

  // divide ratio for a master divider code
  function automatic logic [2:0] div_ratio(input logic [1:0] code);
    unique case (code)
      MASTER_DIV_CODE_DIV1: div_ratio = 3'd1;
      MASTER_DIV_CODE_DIV2: div_ratio = 3'd2;
      MASTER_DIV_CODE_DIV4: div_ratio = 3'd4;
      MASTER_DIV_CODE_DIV3: div_ratio = 3'd3;
    endcase
  endfunction

  scsmd_slow_ctl_t slow_ctl_q; // backup domain control
  scsmd_div_ctl_t div_ctl_q; // core domain divider control
  logic active_sel_q; // resynchronised select driving the mux
  scsmd_sw_state_t sw_state_q; // switch sequencer
  logic [2:0] resync_cnt_q; // slow ticks seen on the new source
  logic slow_in_q; // previous level of external slow input
  logic presc_q; // usb pll prescaler phase
  logic [2:0] master_div_code_cnt_q; // master divider phase
  logic [3:0] fs_cnt_q; // fs usb divider phase
  // bus holding registers
  logic aw_got_q;
  logic w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  // registered clock ticks
  logic slow_tick_q;
  logic cpu_tick_q;
  logic master_tick_q;
  logic ddr_tick_q;
  logic fs_tick_q;

  logic xtal_path_tick; // crystal or bypass path
  logic rc_path_tick; // internal rc path
  logic target_tick; // tick of the source being switched to
  logic cpu_tick; // system input after prescaler
  logic [2:0] ratio;
  logic [2:0] half;
  logic fs_in_tick;
  logic do_write;
  logic [DATA_W-1:0] rd_word;

  // oscillators run while their enable bit is set
  assign rc_osc_run = slow_ctl_q.rc_osc_on;
  assign xtal_osc_run = slow_ctl_q.xtal_osc_on;

  // bypass replaces the crystal output with rising edges of the pin
  assign xtal_path_tick = slow_ctl_q.xtal_bypass ? (slow_clk_in & ~slow_in_q)
                                                 : (slow_ctl_q.xtal_osc_on & xtal_osc_tick);
  assign rc_path_tick = slow_ctl_q.rc_osc_on & rc_osc_tick;
  assign target_tick = slow_ctl_q.slow_src_sel ? xtal_path_tick : rc_path_tick;

  // external slow input edge history, input taken as synchronous
  always_ff @(posedge clock)
  begin
    if (backup_por)
      slow_in_q <= 1'b0;
    else
      slow_in_q <= slow_clk_in;
  end

  // select resync: the mux moves only after five ticks of the new source,
  // so the dying oscillator is never sampled mid-switch
  always_ff @(posedge clock)
  begin
    if (backup_por)
    begin
      sw_state_q <= SW_IDLE;
      active_sel_q <= 1'b0;
      resync_cnt_q <= 3'd0;
    end
    else
    begin
      unique case (sw_state_q)
        SW_IDLE:
        begin
          resync_cnt_q <= 3'd0;
          // a select change opens a resync window
          if (slow_ctl_q.slow_src_sel != active_sel_q)
            sw_state_q <= SW_RESYNC;
        end
        SW_RESYNC:
        begin
          if (slow_ctl_q.slow_src_sel == active_sel_q)
          begin
            // select written back before completion: cancel
            sw_state_q <= SW_IDLE;
          end
          else if (target_tick)
          begin
            if (resync_cnt_q == SLOW_RESYNC_CYCLES - 3'd1)
            begin
              active_sel_q <= slow_ctl_q.slow_src_sel;
              sw_state_q <= SW_IDLE;
            end
            else
              resync_cnt_q <= resync_cnt_q + 3'd1;
          end
        end
      endcase
    end
  end

  // ticks are single pulses, so changing the select between them
  // cannot shorten or split a slow clock period
  always_ff @(posedge clock)
  begin
    if (backup_por)
      slow_tick_q <= 1'b0;
    else
      slow_tick_q <= active_sel_q ? xtal_path_tick : rc_path_tick;
  end

  // usb mode: system input is the usb pll halved
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      presc_q <= 1'b0;
    else if (usb_pll_tick)
      presc_q <= ~presc_q;
  end
  assign cpu_tick = div_ctl_q.usb_sys_mode ? (usb_pll_tick & presc_q) : main_pll_tick;

  assign ratio = div_ratio(div_ctl_q.master_div_code);
  assign half = ratio >> 1;

  // master divider phase counter on cpu ticks
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      master_div_code_cnt_q <= 3'd0;
    else if (master_div_code_cnt_q >= ratio - 3'd1)
    begin
      // also recovers when the ratio shrinks mid-count
      if (cpu_tick || master_div_code_cnt_q > ratio - 3'd1)
        master_div_code_cnt_q <= 3'd0;
    end
    else if (cpu_tick)
      master_div_code_cnt_q <= master_div_code_cnt_q + 3'd1;
  end

  // registered cpu, master and ddr ticks
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cpu_tick_q <= 1'b0;
      master_tick_q <= 1'b0;
      ddr_tick_q <= 1'b0;
    end
    else
    begin
      cpu_tick_q <= cpu_tick;
      master_tick_q <= cpu_tick && (master_div_code_cnt_q == ratio - 3'd1);
      // two ddr ticks per master period; ratio 3 gives uneven spacing
      ddr_tick_q <= cpu_tick && (ratio != 3'd1)
                    && ((master_div_code_cnt_q == ratio - 3'd1) || (master_div_code_cnt_q == half - 3'd1));
    end
  end
  assign ddr_clk_avail = (ratio != 3'd1);

  // fs usb divider: divide by programmed value plus one
  assign fs_in_tick = div_ctl_q.fs_src_main ? main_pll_tick : usb_pll_tick;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fs_cnt_q <= 4'd0;
      fs_tick_q <= 1'b0;
    end
    else
    begin
      fs_tick_q <= fs_in_tick && (fs_cnt_q >= div_ctl_q.fs_usb_div);
      if (fs_in_tick)
        fs_cnt_q <= (fs_cnt_q >= div_ctl_q.fs_usb_div) ? 4'd0 : fs_cnt_q + 4'd1;
    end
  end

  assign slow_clk_tick = slow_tick_q;
  assign cpu_clk_tick = cpu_tick_q;
  assign master_clk_tick = master_tick_q;
  assign ddr_clk_tick = ddr_tick_q;
  assign fs_usb_tick = fs_tick_q;

  // write channel capture: address and data taken in either order
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign do_write = aw_got_q & w_got_q & ~bvalid_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        // status is read only, so a write there is an error too
        bresp_q <= (is_mapped(awaddr_q) && awaddr_q != STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // slow control lives on the backup supply: core reset leaves it alone
  always_ff @(posedge clock)
  begin
    if (backup_por)
      slow_ctl_q <= scsmd_slow_ctl_t'(SLOW_CTL_RST);
    else if (do_write && awaddr_q == SLOW_CTL_OFFSET && wstrb_q[0])
    begin
      slow_ctl_q.rc_osc_on <= wdata_q[RC_OSC_ON_BIT];
      slow_ctl_q.xtal_osc_on <= wdata_q[XTAL_OSC_ON_BIT];
      slow_ctl_q.xtal_bypass <= wdata_q[XTAL_BYPASS_BIT];
      slow_ctl_q.slow_src_sel <= wdata_q[SLOW_SRC_SEL_BIT];
    end
  end

  // divider control, byte lanes honoured, reserved bits stay zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      div_ctl_q <= scsmd_div_ctl_t'(DIV_CTL_RST);
    else if (do_write && awaddr_q == DIV_CTL_OFFSET)
    begin
      if (wstrb_q[0])
      begin
        div_ctl_q.master_div_code <= wdata_q[MASTER_DIV_CODE_LSB +: 2];
        div_ctl_q.fs_usb_div <= wdata_q[FS_DIV_LSB +: 4];
      end
      if (wstrb_q[1])
      begin
        div_ctl_q.usb_sys_mode <= wdata_q[USB_SYS_MODE_BIT];
        div_ctl_q.fs_src_main <= wdata_q[FS_SRC_MAIN_BIT];
      end
      div_ctl_q.rsvd <= 2'b00;
    end
  end

  // read mux, unused bits read zero
  always_comb
  begin
    rd_word = '0;
    if (s_axi_araddr == SLOW_CTL_OFFSET)
      rd_word[SLOW_CTL_W-1:0] = slow_ctl_q;
    else if (s_axi_araddr == DIV_CTL_OFFSET)
      rd_word[DIV_CTL_W-1:0] = div_ctl_q;
    else if (s_axi_araddr == STATUS_OFFSET)
    begin
      rd_word[STS_ACTIVE_SEL_BIT] = active_sel_q;
      rd_word[STS_SWITCH_BUSY_BIT] = (sw_state_q == SW_RESYNC);
      rd_word[STS_DDR_AVAIL_BIT] = ddr_clk_avail;
    end
  end

  // read channel: answer one cycle after the address is taken
  assign s_axi_arready = ~rvalid_q;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule
